// ===== rtl/airq_pkg.sv
// package: register map, field layout and codes of the interrupt register block
package airq_pkg;
  // register indices on the plain port (byte address)
  localparam logic [7:0] ADDR_THRESHOLD = 8'h80;
  localparam logic [7:0] ADDR_SNAPSHOT = 8'h81;
  localparam logic [7:0] ADDR_VECTOR = 8'h82;
  localparam logic [7:0] ADDR_GLOBAL_CFG = 8'h83;
  localparam logic [7:0] ADDR_INT_CHANNEL = 8'h84;
  localparam logic [7:0] ADDR_BYTE_COUNT = 8'h85;
  localparam logic [7:0] ADDR_INT_TYPE = 8'h86;
  localparam logic [7:0] ADDR_RX_FIFO = 8'h87;
  localparam logic [7:0] ADDR_UPDATE_CMD = 8'h8C;

  // reset values
  localparam logic [7:0] THRESHOLD_RST = 8'h00;
  localparam logic [7:0] VECTOR_RST = 8'h0F;
  localparam logic [1:0] VCFG_RST = 2'h0;
  localparam logic [7:0] ZERO8 = 8'h00;

  // vector configuration field values
  localparam logic [1:0] VCFG_PLAIN = 2'h1;
  localparam logic [1:0] VCFG_TYPE = 2'h3;

  // snapshot classes in bits 7:6
  localparam logic [1:0] CLS_OTHER = 2'h0;
  localparam logic [1:0] CLS_TX = 2'h1;
  localparam logic [1:0] CLS_RX_OK = 2'h2;
  localparam logic [1:0] CLS_RX_ERR = 2'h3;

  // other-class source codes in bits 5:1
  localparam logic [4:0] SRC_NONE = 5'h00;
  localparam logic [4:0] SRC_COS = 5'h01;
  localparam logic [4:0] SRC_ADDR = 5'h02;
  localparam logic [4:0] SRC_FLOW = 5'h03;
  localparam logic [4:0] SRC_WDOG = 5'h04;
  localparam logic [4:0] SRC_BREAK = 5'h05;
  localparam logic [4:0] SRC_TIMER = 5'h06;
  localparam logic [4:0] SRC_LOOPERR = 5'h07;

  // interrupt-type register: receive codes are inverted against the snapshot
  localparam logic [1:0] TYP_RX_ERR = 2'h2;
  localparam logic [1:0] TYP_RX_OK = 2'h3;

  // bid slots of the arbiter, six of them driven
  localparam int NUM_SRC = 10;
endpackage : airq_pkg

// ===== rtl/airq_bid_arb.sv
// arbitration loop: picks the highest valid bid, among receivers only while the watchdog is pending
`timescale 1ns/1ps
module airq_bid_arb (
  // bids: priority in 10:3, channel in 2:0
  input wire logic [airq_pkg::NUM_SRC*11-1:0] bid_flat,
  input wire logic [airq_pkg::NUM_SRC-1:0] bid_valid,
  input wire logic [airq_pkg::NUM_SRC-1:0] bid_is_rx,
  // receiver watchdog pending: only receiver bids compete
  input wire logic wdog_pending,
  // result
  output logic win_valid,
  output logic [3:0] win_index,
  output logic [10:0] win_bid
);
  always_comb begin
    win_valid = 1'b0;
    win_index = 4'h0;
    win_bid = 11'h000;
    for (int i = 0; i < airq_pkg::NUM_SRC; i++) begin
      if (bid_valid[i] && (!wdog_pending || bid_is_rx[i]) &&
          (!win_valid || bid_flat[i*11 +: 11] > win_bid)) begin
        win_valid = 1'b1;
        win_index = 4'(i);
        win_bid = bid_flat[i*11 +: 11];
      end
    end
  end
endmodule : airq_bid_arb

// ===== rtl/airq_regs.sv
// interrupt snapshot, threshold, vector and global interrupt registers
//
// Contract
// - request only when winning priority exceeds threshold
// - winner below threshold loads snapshot zero
// - watchdog pending: threshold ignored, receivers only
// - bid upper bits priority, low three channel
// - write to update address refreshes snapshot
// - acknowledge cycle start captures winner
// - snapshot frozen between capture events
// - snapshot 7:6 hold interrupt class
// - other-class source codes in 5:1
// - tx/rx count code in 5:1
// - snapshot bit 0 names channel
// - config 01 gives plain vector
// - vector bits modified by configuration field
// - global reads follow snapshot channel
// - channel register bit 0, rest zero
// - byte count latched, 256 reads zero
// - type register layout, receive codes inverted
// - global receive read pops snapshot channel
//
// Strobed register access and the register offsets were left to the implementer.
`timescale 1ns/1ps
module airq_regs (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // interrupt pins
  input wire logic interrupt_acknowledge_n,
  output logic interrupt_request_n,
  output logic [7:0] vector_out,
  output logic vector_out_en_n,
  // per channel pending sources, bit order: cos, addr, flow, wdog, break,
  // timer, looperr
  input wire logic [6:0] src_pend_a,
  input wire logic [6:0] src_pend_b,
  input wire logic [7:0] src_prio_a,
  input wire logic [7:0] src_prio_b,
  // fifo status per channel
  input wire logic tx_req_a,
  input wire logic tx_req_b,
  input wire logic rx_req_a,
  input wire logic rx_req_b,
  input wire logic rx_err_a,
  input wire logic rx_err_b,
  input wire logic [7:0] tx_prio_a,
  input wire logic [7:0] tx_prio_b,
  input wire logic [7:0] rx_prio_a,
  input wire logic [7:0] rx_prio_b,
  input wire logic [8:0] transmit_empty_slots_a,
  input wire logic [8:0] transmit_empty_slots_b,
  input wire logic [8:0] receive_fill_level_a,
  input wire logic [8:0] receive_fill_level_b,
  // receive fifo data and pop
  input wire logic [7:0] rx_data_a,
  input wire logic [7:0] rx_data_b,
  output logic rx_pop_a,
  output logic rx_pop_b
);
  // ------------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------------
  logic ack_s1_ff, ack_s2_ff, ack_d_ff;
  logic nxt_ack_s1, nxt_ack_s2, nxt_ack_d;

  // ------------------------------------------------------------------
  // register state
  // ------------------------------------------------------------------
  logic [7:0] arbitration_threshold_ff, nxt_arbitration_threshold;
  logic [7:0] interrupt_vector_byte_ff, nxt_interrupt_vector_byte;
  logic [1:0] vector_config_field_ff, nxt_vector_config_field;
  logic [7:0] current_interrupt_snapshot_ff, nxt_snapshot;
  logic [8:0] count_ff, nxt_count;
  logic [7:0] rdata_ff, nxt_rdata;
  logic irq_n_ff, nxt_irq_n;
  logic [7:0] vec_ff, nxt_vec;
  logic vec_en_n_ff, nxt_vec_en_n;

  // ------------------------------------------------------------------
  // bids
  // ------------------------------------------------------------------
  localparam int NS = airq_pkg::NUM_SRC;
  logic [NS*11-1:0] bid_flat;
  logic [NS-1:0] bid_valid, bid_is_rx;
  logic win_valid;
  logic [3:0] win_index;
  logic [10:0] win_bid;
  logic wdog_pending;

  function automatic logic [10:0] mk_bid(input logic [7:0] p,
                                         input logic ch);
    mk_bid = {p, 2'b00, ch};
  endfunction : mk_bid

  // source index: 0/1 other, 2/3 tx, 4/5 rx, channel a then b in each pair
  always_comb begin
    bid_flat = '0;
    bid_valid = '0;
    bid_is_rx = '0;
    // channel a other sources share one priority, one bidder for lowest
    for (int i = 0; i < 3; i++) begin
      bid_valid[i] = 1'b0;
    end
    bid_valid[0] = |src_pend_a;
    bid_flat[0*11 +: 11] = mk_bid(src_prio_a, 1'b0);
    bid_valid[1] = |src_pend_b;
    bid_flat[1*11 +: 11] = mk_bid(src_prio_b, 1'b1);
    bid_valid[2] = tx_req_a;
    bid_flat[2*11 +: 11] = mk_bid(tx_prio_a, 1'b0);
    bid_valid[3] = tx_req_b;
    bid_flat[3*11 +: 11] = mk_bid(tx_prio_b, 1'b1);
    bid_valid[4] = rx_req_a;
    bid_is_rx[4] = 1'b1;
    bid_flat[4*11 +: 11] = mk_bid(rx_prio_a, 1'b0);
    bid_valid[5] = rx_req_b;
    bid_is_rx[5] = 1'b1;
    bid_flat[5*11 +: 11] = mk_bid(rx_prio_b, 1'b1);
  end

  assign wdog_pending = src_pend_a[3] | src_pend_b[3];

  airq_bid_arb u_arb (
    .bid_flat(bid_flat),
    .bid_valid(bid_valid),
    .bid_is_rx(bid_is_rx),
    .wdog_pending(wdog_pending),
    .win_valid(win_valid),
    .win_index(win_index),
    .win_bid(win_bid)
  );

  // ------------------------------------------------------------------
  // winner decode
  // ------------------------------------------------------------------
  logic above;
  logic win_ch;
  logic [7:0] win_code;
  logic [8:0] win_count;

  function automatic logic [4:0] src_code(input logic [6:0] p);
    src_code = airq_pkg::SRC_NONE;
    for (int k = 6; k >= 0; k--) begin
      if (p[k]) begin
        src_code = 5'(k + 1);
      end
    end
  endfunction : src_code

  // coarse count: 0 => >=1, 1 => >=16, then one step per 8 characters
  function automatic logic [4:0] cnt_code(input logic [8:0] n);
    if (n < 9'd16) begin
      cnt_code = 5'h00;
    end else begin
      cnt_code = 5'(((n - 9'd16) >> 3) + 9'd1);
    end
  endfunction : cnt_code

  always_comb begin
    win_ch = win_bid[0];
    above = win_valid && (wdog_pending ||
            win_bid[10:3] > arbitration_threshold_ff);
    win_code = airq_pkg::ZERO8;
    win_count = 9'h000;
    unique case (win_index)
      4'h0: win_code = {airq_pkg::CLS_OTHER, src_code(src_pend_a), 1'b0};
      4'h1: win_code = {airq_pkg::CLS_OTHER, src_code(src_pend_b), 1'b1};
      4'h2: begin
        win_code = {airq_pkg::CLS_TX, cnt_code(transmit_empty_slots_a), 1'b0};
        win_count = transmit_empty_slots_a;
      end
      4'h3: begin
        win_code = {airq_pkg::CLS_TX, cnt_code(transmit_empty_slots_b), 1'b1};
        win_count = transmit_empty_slots_b;
      end
      4'h4: begin
        win_code = {rx_err_a ? airq_pkg::CLS_RX_ERR : airq_pkg::CLS_RX_OK,
                    cnt_code(receive_fill_level_a), 1'b0};
        win_count = receive_fill_level_a;
      end
      4'h5: begin
        win_code = {rx_err_b ? airq_pkg::CLS_RX_ERR : airq_pkg::CLS_RX_OK,
                    cnt_code(receive_fill_level_b), 1'b1};
        win_count = receive_fill_level_b;
      end
      default: win_code = airq_pkg::ZERO8;
    endcase
    if (!above) begin
      win_code = airq_pkg::ZERO8;
    end
  end

  // ------------------------------------------------------------------
  // capture, register writes, reads
  // ------------------------------------------------------------------
  logic ack_start, upd_cmd, capture;
  logic snap_ch;
  logic [1:0] snap_cls;
  logic [7:0] type_reg;

  assign ack_start = ack_d_ff & ~ack_s2_ff;
  assign upd_cmd = reg_wr && reg_addr == airq_pkg::ADDR_UPDATE_CMD;
  assign capture = ack_start | upd_cmd;
  assign snap_ch = current_interrupt_snapshot_ff[0];
  assign snap_cls = current_interrupt_snapshot_ff[7:6];

  always_comb begin
    type_reg = airq_pkg::ZERO8;
    if (snap_cls == airq_pkg::CLS_RX_ERR) begin
      type_reg[7:6] = airq_pkg::TYP_RX_ERR;
    end else if (snap_cls == airq_pkg::CLS_RX_OK) begin
      type_reg[7:6] = airq_pkg::TYP_RX_OK;
    end else if (snap_cls == airq_pkg::CLS_TX) begin
      type_reg[5] = 1'b1;
    end else begin
      type_reg[2:0] = current_interrupt_snapshot_ff[3:1];
    end
  end

  always_comb begin
    nxt_ack_s1 = interrupt_acknowledge_n;
    nxt_ack_s2 = ack_s1_ff;
    nxt_ack_d = ack_s2_ff;
    nxt_arbitration_threshold = arbitration_threshold_ff;
    nxt_interrupt_vector_byte = interrupt_vector_byte_ff;
    nxt_vector_config_field = vector_config_field_ff;
    nxt_snapshot = current_interrupt_snapshot_ff;
    nxt_count = count_ff;
    nxt_rdata = rdata_ff;
    rx_pop_a = 1'b0;
    rx_pop_b = 1'b0;
    if (capture) begin
      nxt_snapshot = win_code;
      nxt_count = win_count;
    end
    if (reg_wr) begin
      unique case (reg_addr)
        airq_pkg::ADDR_THRESHOLD: nxt_arbitration_threshold = reg_wdata;
        airq_pkg::ADDR_VECTOR: nxt_interrupt_vector_byte = reg_wdata;
        airq_pkg::ADDR_GLOBAL_CFG: nxt_vector_config_field = reg_wdata[2:1];
        default: ;
      endcase
    end
    if (reg_rd) begin
      unique case (reg_addr)
        airq_pkg::ADDR_THRESHOLD: nxt_rdata = arbitration_threshold_ff;
        airq_pkg::ADDR_SNAPSHOT: nxt_rdata = current_interrupt_snapshot_ff;
        airq_pkg::ADDR_VECTOR: nxt_rdata = interrupt_vector_byte_ff;
        airq_pkg::ADDR_GLOBAL_CFG:
          nxt_rdata = {5'h00, vector_config_field_ff, 1'b0};
        airq_pkg::ADDR_INT_CHANNEL: nxt_rdata = {7'h00, snap_ch};
        airq_pkg::ADDR_BYTE_COUNT: nxt_rdata = count_ff[7:0];
        airq_pkg::ADDR_INT_TYPE: nxt_rdata = type_reg;
        airq_pkg::ADDR_RX_FIFO: begin
          nxt_rdata = snap_ch ? rx_data_b : rx_data_a;
          rx_pop_a = ~snap_ch;
          rx_pop_b = snap_ch;
        end
        default: nxt_rdata = airq_pkg::ZERO8;
      endcase
    end else begin
      nxt_rdata = airq_pkg::ZERO8;
    end
  end

  // ------------------------------------------------------------------
  // request pin and vector drive
  // ------------------------------------------------------------------
  always_comb begin
    nxt_irq_n = ~above;
    nxt_vec = vec_ff;
    nxt_vec_en_n = 1'b1;
    if (!ack_s2_ff && vector_config_field_ff != 2'h0) begin
      nxt_vec_en_n = 1'b0;
    end
    if (ack_start) begin
      nxt_vec = interrupt_vector_byte_ff;
      if (vector_config_field_ff == airq_pkg::VCFG_TYPE) begin
        nxt_vec[2:1] = win_code[7:6];
      end
      if (vector_config_field_ff > airq_pkg::VCFG_PLAIN) begin
        nxt_vec[0] = win_code[0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ack_s1_ff <= 1'b1;
      ack_s2_ff <= 1'b1;
      ack_d_ff <= 1'b1;
      arbitration_threshold_ff <= airq_pkg::THRESHOLD_RST;
      interrupt_vector_byte_ff <= airq_pkg::VECTOR_RST;
      vector_config_field_ff <= airq_pkg::VCFG_RST;
      current_interrupt_snapshot_ff <= airq_pkg::ZERO8;
      count_ff <= 9'h000;
      rdata_ff <= airq_pkg::ZERO8;
      irq_n_ff <= 1'b1;
      vec_ff <= airq_pkg::ZERO8;
      vec_en_n_ff <= 1'b1;
    end else begin
      ack_s1_ff <= nxt_ack_s1;
      ack_s2_ff <= nxt_ack_s2;
      ack_d_ff <= nxt_ack_d;
      arbitration_threshold_ff <= nxt_arbitration_threshold;
      interrupt_vector_byte_ff <= nxt_interrupt_vector_byte;
      vector_config_field_ff <= nxt_vector_config_field;
      current_interrupt_snapshot_ff <= nxt_snapshot;
      count_ff <= nxt_count;
      rdata_ff <= nxt_rdata;
      irq_n_ff <= nxt_irq_n;
      vec_ff <= nxt_vec;
      vec_en_n_ff <= nxt_vec_en_n;
    end
  end

  assign reg_rdata = rdata_ff;
  assign interrupt_request_n = irq_n_ff;
  assign vector_out = vec_ff;
  assign vector_out_en_n = vec_en_n_ff;

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  a_irq_follows: assert property (@(posedge clk) disable iff (rst)
    !above |=> interrupt_request_n)
    else $error("request asserted while no bid above threshold");
  a_irq_drops: assert property (@(posedge clk) disable iff (rst)
    above ##1 !above |=> interrupt_request_n)
    else $error("request not released");
  a_snap_zero: assert property (@(posedge clk) disable iff (rst)
    capture && !above |=> current_interrupt_snapshot_ff == 8'h00)
    else $error("snapshot not zero below threshold");
  a_snap_frozen: assert property (@(posedge clk) disable iff (rst)
    !capture |=> $stable(current_interrupt_snapshot_ff))
    else $error("snapshot changed without capture");
  a_upd_capture: assert property (@(posedge clk) disable iff (rst)
    upd_cmd |=> current_interrupt_snapshot_ff == $past(win_code))
    else $error("update command did not capture winner");
  a_ack_capture: assert property (@(posedge clk) disable iff (rst)
    $fell(ack_s2_ff) |=> current_interrupt_snapshot_ff == $past(win_code))
    else $error("acknowledge did not capture winner");
  a_chan_read: assert property (@(posedge clk) disable iff (rst)
    reg_rd && reg_addr == airq_pkg::ADDR_INT_CHANNEL
    |=> reg_rdata == {7'h00, $past(snap_ch)})
    else $error("channel register wrong");
  a_rx_pop: assert property (@(posedge clk) disable iff (rst)
    reg_rd && reg_addr == airq_pkg::ADDR_RX_FIFO
    |-> rx_pop_b == snap_ch && rx_pop_a == !snap_ch)
    else $error("pop went to wrong channel");
  a_vec_plain: assert property (@(posedge clk) disable iff (rst)
    ack_start && vector_config_field_ff == airq_pkg::VCFG_PLAIN
    |=> vector_out == $past(interrupt_vector_byte_ff))
    else $error("plain vector modified");
endmodule : airq_regs

// ===== testbench/airq_host_model.sv
// host bus master model: register port cycles and acknowledge pin
`timescale 1ns/1ps
module airq_host_model (
  // clock
  input wire logic clk,
  // register port
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // interrupt pins
  output logic interrupt_acknowledge_n,
  input wire logic [7:0] vector_out,
  input wire logic vector_out_en_n
);
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    interrupt_acknowledge_n = 1'b1;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    // idle bus shows the inverse, so a stale value can never match
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    #1;
    d = reg_rdata;
  endtask : rd
  task automatic ack(output logic [7:0] vec, output logic en_n);
    @(posedge clk);
    interrupt_acknowledge_n <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
    vec = vector_out;
    en_n = vector_out_en_n;
    @(posedge clk);
    interrupt_acknowledge_n <= 1'b1;
    repeat (4) @(posedge clk);
  endtask : ack
  // receive first, then transmit, else zero for the other class
  function automatic logic [1:0] decode(input logic [7:0] snap);
    if (snap[7]) return 2'h2;
    else if (snap[6]) return 2'h1;
    return 2'h0;
  endfunction : decode
endmodule : airq_host_model

// ===== testbench/airq_regs_tb.sv
// self-checking bench of the interrupt register block
`timescale 1ns/1ps
module airq_regs_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, vector_out;
  logic reg_wr, reg_rd, interrupt_acknowledge_n;
  logic interrupt_request_n, vector_out_en_n, rx_pop_a, rx_pop_b;
  logic [6:0] src_pend_a = 7'h00, src_pend_b = 7'h00;
  logic [7:0] src_prio_a = 8'h20, src_prio_b = 8'h20;
  logic tx_req_a = 1'b0, tx_req_b = 1'b0, rx_req_a = 1'b0, rx_req_b = 1'b0;
  logic rx_err_a = 1'b0, rx_err_b = 1'b0;
  logic [7:0] tx_prio_a = 8'h50, tx_prio_b = 8'h50;
  logic [7:0] rx_prio_a = 8'h50, rx_prio_b = 8'h50;
  logic [8:0] transmit_empty_slots_a = 9'h001, transmit_empty_slots_b = 9'h001;
  logic [8:0] receive_fill_level_a = 9'h001, receive_fill_level_b = 9'h001;
  logic [7:0] rx_data_a = 8'h5A, rx_data_b = 8'hA5;
  logic [7:0] vec;
  logic en_n;
  int mismatches = 0;
  int samples_checked = 0;
  int pops_a = 0;
  int pops_b = 0;

  always #2.5 clk = ~clk;

  airq_regs airq_regs_i (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .interrupt_acknowledge_n, .interrupt_request_n, .vector_out,
    .vector_out_en_n, .src_pend_a, .src_pend_b, .src_prio_a, .src_prio_b,
    .tx_req_a, .tx_req_b, .rx_req_a, .rx_req_b, .rx_err_a, .rx_err_b,
    .tx_prio_a, .tx_prio_b, .rx_prio_a, .rx_prio_b, .transmit_empty_slots_a,
    .transmit_empty_slots_b, .receive_fill_level_a, .receive_fill_level_b,
    .rx_data_a, .rx_data_b, .rx_pop_a, .rx_pop_b);
  airq_host_model airq_host_model_i (.clk, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .interrupt_acknowledge_n, .vector_out,
    .vector_out_en_n);

  always @(posedge clk) begin
    if (rx_pop_a === 1'b1) pops_a++;
    if (rx_pop_b === 1'b1) pops_b++;
  end

  task automatic results;
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : results
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
      mismatches++;
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    airq_host_model_i.wr(a, d);
  endtask : wr
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    airq_host_model_i.rd(a, d);
    check(d, e);
  endtask : rchk
  task automatic set_src(input logic [3:0] req, input logic err,
    input logic [8:0] n, input logic [6:0] pb);
    @(posedge clk);
    {rx_req_b, rx_req_a, tx_req_b, tx_req_a} <= req;
    rx_err_a <= err;
    rx_err_b <= err;
    transmit_empty_slots_a <= n;
    transmit_empty_slots_b <= n;
    receive_fill_level_a <= n;
    receive_fill_level_b <= n;
    src_pend_b <= pb;
    repeat (3) @(posedge clk);
    #1;
  endtask : set_src
  task automatic prio_a(input logic [7:0] p);
    @(posedge clk);
    tx_prio_a <= p;
    repeat (3) @(posedge clk);
    #1;
  endtask : prio_a
  function automatic logic [4:0] cnt_code(input logic [8:0] n);
    logic [8:0] c;
    c = ((n - 9'h010) >> 3) + 9'h001;
    return (n < 9'h010) ? 5'h00 : c[4:0];
  endfunction : cnt_code
  task automatic fifo_case(input logic [3:0] req, input logic err,
    input logic [8:0] n, input logic [1:0] cls, input logic ch);
    logic [7:0] ty;
    logic [7:0] s;
    ty = cls[1] ? (cls[0] ? 8'h80 : 8'hC0) : 8'h20;
    set_src(req, err, n, 7'h00);
    wr(airq_pkg::ADDR_UPDATE_CMD, 8'h00);
    airq_host_model_i.rd(airq_pkg::ADDR_SNAPSHOT, s);
    check(s, {cls, cnt_code(n), ch});
    check({6'h00, airq_host_model_i.decode(s)},
      {6'h00, cls[1] ? 2'h2 : 2'h1});
    rchk(airq_pkg::ADDR_BYTE_COUNT, n[7:0]);
    rchk(airq_pkg::ADDR_INT_CHANNEL, {7'h00, ch});
    rchk(airq_pkg::ADDR_INT_TYPE, ty);
    if (cls[1]) rchk(airq_pkg::ADDR_RX_FIFO, ch ? 8'hA5 : 8'h5A);
  endtask : fifo_case

  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    results();
  end

  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rchk(airq_pkg::ADDR_THRESHOLD, 8'h00);
    rchk(airq_pkg::ADDR_VECTOR, 8'h0F);
    rchk(airq_pkg::ADDR_SNAPSHOT, 8'h00);
    wr(8'h91, 8'hFF);
    rchk(8'h91, 8'h00);
    check({6'h00, interrupt_request_n, vector_out_en_n}, 8'h03);
    // threshold compare, equal is not enough
    wr(airq_pkg::ADDR_THRESHOLD, 8'h40);
    rchk(airq_pkg::ADDR_THRESHOLD, 8'h40);
    prio_a(8'h40);
    set_src(4'b0001, 1'b0, 9'h001, 7'h00);
    check({7'h00, interrupt_request_n}, 8'h01);
    prio_a(8'h41);
    check({7'h00, interrupt_request_n}, 8'h00);
    set_src(4'b0000, 1'b0, 9'h001, 7'h00);
    check({7'h00, interrupt_request_n}, 8'h01);
    prio_a(8'h3F);
    set_src(4'b0001, 1'b0, 9'h001, 7'h00);
    wr(airq_pkg::ADDR_UPDATE_CMD, 8'hFF);
    rchk(airq_pkg::ADDR_SNAPSHOT, 8'h00);
    prio_a(8'h50);
    wr(airq_pkg::ADDR_THRESHOLD, 8'h00);
    // fifo classes, counts and channels; equal priorities go to B
    fifo_case(4'b0010, 1'b0, 9'h100, airq_pkg::CLS_TX, 1'b1);
    fifo_case(4'b0100, 1'b0, 9'h018, airq_pkg::CLS_RX_OK, 1'b0);
    fifo_case(4'b1000, 1'b1, 9'h005, airq_pkg::CLS_RX_ERR, 1'b1);
    fifo_case(4'b0011, 1'b0, 9'h010, airq_pkg::CLS_TX, 1'b1);
    check(8'(pops_a * 16 + pops_b), 8'h11);
    // other sources on channel B; the watchdog bit is tested below
    for (int i = 0; i < 7; i++) begin
      if (i != 3) begin
        set_src(4'b0000, 1'b0, 9'h001, 7'(1 << i));
        wr(airq_pkg::ADDR_UPDATE_CMD, 8'h00);
        rchk(airq_pkg::ADDR_SNAPSHOT, {2'h0, 5'(i + 1), 1'b1});
        rchk(airq_pkg::ADDR_INT_TYPE, {5'h00, 3'(i + 1)});
      end
    end
    // watchdog: low receiver bid wins over threshold and higher bids
    wr(airq_pkg::ADDR_THRESHOLD, 8'hF0);
    @(posedge clk);
    src_prio_a <= 8'hFF;
    rx_prio_b <= 8'h10;
    tx_prio_a <= 8'hFE;
    src_pend_a <= 7'h08;
    set_src(4'b1001, 1'b0, 9'h001, 7'h00);
    check({7'h00, interrupt_request_n}, 8'h00);
    wr(airq_pkg::ADDR_UPDATE_CMD, 8'h00);
    rchk(airq_pkg::ADDR_SNAPSHOT, 8'h81);
    @(posedge clk);
    src_pend_a <= 7'h00;
    wr(airq_pkg::ADDR_THRESHOLD, 8'h00);
    set_src(4'b0010, 1'b0, 9'h001, 7'h00);
    rchk(airq_pkg::ADDR_SNAPSHOT, 8'h81);
    // acknowledge captures and presents the vector per configuration
    wr(airq_pkg::ADDR_VECTOR, 8'hA8);
    for (int c = 0; c < 4; c++) begin
      wr(airq_pkg::ADDR_GLOBAL_CFG, {5'h00, 2'(c), 1'b0});
      airq_host_model_i.ack(vec, en_n);
      if (c == 0) rchk(airq_pkg::ADDR_SNAPSHOT, 8'h41);
      check({7'h00, en_n}, (c == 0) ? 8'h01 : 8'h00);
      if (c == 1) check(vec, 8'hA8);
      if (c == 2) check(vec, 8'hA9);
      if (c == 3) check(vec, 8'hAB);
    end
    results();
  end
endmodule : airq_regs_tb
